// ### inc/pcc_consts.svh
// constants of the configuration identity and command block
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH
`define PCC_DW_W 6
`define PCC_DW_ID 6'h00
`define PCC_DW_CMD 6'h01
`define PCC_CMD_W 16
`define PCC_CMD_RST 16'h0000
`define PCC_BIT_IO 0
`define PCC_BIT_MEM 1
`define PCC_BIT_BM 2
`define PCC_BIT_SPC 3
`define PCC_BIT_MWI 4
`define PCC_BIT_PAL 5
`define PCC_BIT_PAR 6
`define PCC_BIT_STEP 7
`define PCC_BIT_SYS 8
`define PCC_BIT_FB2B 9
`define PCC_STS_DPE 31
`define PCC_BE_CMD_LO 0
`define PCC_BE_CMD_HI 1
`define PCC_BE_STS_HI 3
`define PCC_VENDOR_DEF 16'h1A2B
`define PCC_DEVICE_DEF 16'h3C4D
`define PCC_RST_SYNC_W 2
`endif

// ### inc/pcc_pkg.sv
// types of the configuration identity and command block
`include "pcc_consts.svh"
package pcc_pkg;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [`PCC_DW_W-1:0] dw;
		logic [3:0] be;
		logic [31:0] wdata;
	} pcc_cfg_req_t;

	typedef struct packed {
		logic fast_b2b;
		logic system_error_report_en;
		logic parity_error_response;
		logic write_invalidate_allow;
		logic bus_master_allow;
		logic memory_space_allow;
		logic io_space_allow;
	} pcc_cmd_t;

	typedef struct packed {
		pcc_cmd_t cmd;
		logic detected_parity_flag;
		logic sys_err_drive;
		logic par_err_drive;
		logic data_parity_seen;
		logic rvalid;
		logic [31:0] rdata;
	} pcc_state_t;

	typedef struct packed {
		logic [15:0] vendor;
		logic [15:0] device;
	} pcc_id_t;
endpackage

// ### rtl/pcc_id_store.sv
// identity codes taken from the serial eeprom or built-in defaults
`timescale 1ns/100ps
`default_nettype none
`include "pcc_consts.svh"
module pcc_id_store
	import pcc_pkg::*;
#(
	parameter logic [15:0] VENDOR_DEF = `PCC_VENDOR_DEF,
	parameter logic [15:0] DEVICE_DEF = `PCC_DEVICE_DEF
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic eeprom_present,
	input wire logic eeprom_load,
	input wire pcc_id_t eeprom_ids,
	output var pcc_id_t ids
);
	pcc_id_t id_reg;
	pcc_id_t id_next;

	always_comb begin
		id_next = id_reg;
		if (eeprom_load && eeprom_present) begin
			id_next = eeprom_ids;
		end else if (eeprom_load) begin
			id_next.vendor = VENDOR_DEF;
			id_next.device = DEVICE_DEF;
		end
	end

	// defaults are arbitrary neutral codes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			id_reg <= {VENDOR_DEF, DEVICE_DEF};
		end else begin
			id_reg <= id_next;
		end
	end

	assign ids = id_reg;
endmodule
`default_nettype wire

// ### rtl/pcc_cmd_regs.sv
// configuration identity and command register bank with cycle gating
// Operation
// - The vendor code comes from the eeprom at load, else a built-in code.
// - The device code comes from the eeprom at load, else a built-in code.
// - The command register is 16 bits and bits 15 to 10 are reserved.
// - With the fast back-to-back option off, bit 9 reads zero, ignores writes and no such cycles occur.
// - With the option on, bit 9 is read/write, resets to 0 and permits fast cycles to other agents.
// - With bit 8 set, an address phase parity error drives the system error pin.
// - Bit 7 reads zero, ignores writes, and no stepping is ever done.
// - With bit 6 set, a target data parity error drives the parity pin and the master samples it.
// - With bit 6 clear, data parity errors are ignored, and bit 6 resets to 0.
// - Bit 5 palette snoop reads zero and ignores writes.
// - Bit 4 allows write-and-invalidate, else plain memory write is used; it resets to 0.
// - Bit 3 reads zero, ignores writes, and special cycles are ignored.
// - The device requests the bus only while bit 2 is set.
// - Memory accesses are claimed only while bit 1 is set.
// - I/O accesses are claimed only while bit 0 is set.
// - The detected parity flag sets on any parity error regardless of bit 6.
`timescale 1ns/100ps
`default_nettype none
`include "pcc_consts.svh"
module pcc_cmd_regs
	import pcc_pkg::*;
#(
	parameter logic FAST_B2B_OPTION = 1'b0,
	parameter logic [15:0] VENDOR_DEF = `PCC_VENDOR_DEF,
	parameter logic [15:0] DEVICE_DEF = `PCC_DEVICE_DEF
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire pcc_cfg_req_t cfg_req,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	input wire logic eeprom_present,
	input wire logic eeprom_load,
	input wire pcc_id_t eeprom_ids,
	input wire logic io_hit,
	input wire logic mem_hit,
	input wire logic special_cycle,
	output logic io_claim,
	output logic mem_claim,
	input wire logic master_want,
	output logic master_req,
	input wire logic mwi_want,
	output logic use_write_invalidate,
	input wire logic b2b_other_want,
	output logic b2b_other_ok,
	input wire logic addr_parity_err,
	input wire logic target_data_parity_err,
	input wire logic master_active,
	input wire logic parity_error_line_n,
	output logic parity_error_out,
	output logic parity_error_oe_n,
	output logic system_error_out_n,
	output logic system_error_oe_n,
	output logic master_data_parity,
	output logic detected_parity_flag,
	output var pcc_cmd_t cmd_bits,
	output var pcc_id_t ids
);
	logic [`PCC_RST_SYNC_W-1:0] rst_sync_reg;
	logic rst_n;
	pcc_state_t st_reg;
	pcc_state_t st_next;
	logic [`PCC_CMD_W-1:0] cmd_view;
	logic wr_cmd;
	logic master_par;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_reg <= '0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[`PCC_RST_SYNC_W-2:0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[`PCC_RST_SYNC_W-1];

	pcc_id_store #(
		.VENDOR_DEF(VENDOR_DEF),
		.DEVICE_DEF(DEVICE_DEF)
	) u_ids (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.eeprom_present(eeprom_present),
		.eeprom_load(eeprom_load),
		.eeprom_ids(eeprom_ids),
		.ids(ids)
	);

	// read view of the command word; fixed bits stay zero
	always_comb begin
		cmd_view = '0;
		cmd_view[`PCC_BIT_IO] = st_reg.cmd.io_space_allow;
		cmd_view[`PCC_BIT_MEM] = st_reg.cmd.memory_space_allow;
		cmd_view[`PCC_BIT_BM] = st_reg.cmd.bus_master_allow;
		cmd_view[`PCC_BIT_MWI] = st_reg.cmd.write_invalidate_allow;
		cmd_view[`PCC_BIT_PAR] = st_reg.cmd.parity_error_response;
		cmd_view[`PCC_BIT_SYS] = st_reg.cmd.system_error_report_en;
		cmd_view[`PCC_BIT_FB2B] = st_reg.cmd.fast_b2b & FAST_B2B_OPTION;
	end

	assign wr_cmd = cfg_req.wr && (cfg_req.dw == `PCC_DW_CMD);
	assign master_par = master_active && !parity_error_line_n;

	always_comb begin
		st_next = st_reg;
		st_next.rvalid = cfg_req.rd;
		st_next.rdata = st_reg.rdata;
		if (cfg_req.rd) begin
			unique case (cfg_req.dw)
				`PCC_DW_ID: st_next.rdata = {ids.device, ids.vendor};
				`PCC_DW_CMD: begin
					st_next.rdata = {16'h0000, cmd_view};
					st_next.rdata[`PCC_STS_DPE] = st_reg.detected_parity_flag;
				end
				default: st_next.rdata = '0;
			endcase
		end
		if (wr_cmd && cfg_req.be[`PCC_BE_CMD_LO]) begin
			st_next.cmd.io_space_allow = cfg_req.wdata[`PCC_BIT_IO];
			st_next.cmd.memory_space_allow = cfg_req.wdata[`PCC_BIT_MEM];
			st_next.cmd.bus_master_allow = cfg_req.wdata[`PCC_BIT_BM];
			st_next.cmd.write_invalidate_allow = cfg_req.wdata[`PCC_BIT_MWI];
			st_next.cmd.parity_error_response = cfg_req.wdata[`PCC_BIT_PAR];
		end
		if (wr_cmd && cfg_req.be[`PCC_BE_CMD_HI]) begin
			st_next.cmd.system_error_report_en = cfg_req.wdata[`PCC_BIT_SYS];
			st_next.cmd.fast_b2b = cfg_req.wdata[`PCC_BIT_FB2B] & FAST_B2B_OPTION;
		end
		// write one clears the flag; a new error wins
		if (wr_cmd && cfg_req.be[`PCC_BE_STS_HI] && cfg_req.wdata[`PCC_STS_DPE]) begin
			st_next.detected_parity_flag = 1'b0;
		end
		if (addr_parity_err || target_data_parity_err || master_par) begin
			st_next.detected_parity_flag = 1'b1;
		end
		st_next.sys_err_drive = addr_parity_err && st_reg.cmd.system_error_report_en;
		st_next.par_err_drive = target_data_parity_err && st_reg.cmd.parity_error_response;
		st_next.data_parity_seen = master_par && st_reg.cmd.parity_error_response;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign cfg_rdata = st_reg.rdata;
	assign cfg_rvalid = st_reg.rvalid;
	assign io_claim = io_hit && !special_cycle && st_reg.cmd.io_space_allow;
	assign mem_claim = mem_hit && !special_cycle && st_reg.cmd.memory_space_allow;
	assign master_req = master_want && st_reg.cmd.bus_master_allow;
	assign use_write_invalidate = mwi_want && st_reg.cmd.write_invalidate_allow;
	assign b2b_other_ok = b2b_other_want && st_reg.cmd.fast_b2b && FAST_B2B_OPTION;
	assign parity_error_out = 1'b0;
	assign parity_error_oe_n = !st_reg.par_err_drive;
	assign system_error_out_n = 1'b0;
	assign system_error_oe_n = !st_reg.sys_err_drive;
	assign master_data_parity = st_reg.data_parity_seen;
	assign detected_parity_flag = st_reg.detected_parity_flag;
	assign cmd_bits = st_reg.cmd;
endmodule
`default_nettype wire

// ### verif/pcc_bus_peer.sv
// parity line peer with pull-up, sees the device drive too
`timescale 1ns/100ps
`default_nettype none
module pcc_bus_peer (
	input wire logic peer_err,
	input wire logic dev_oe_n,
	output logic line_n
);
	// pulled high unless a party drives it low
	assign line_n = !(peer_err || !dev_oe_n);
endmodule
`default_nettype wire

// ### verif/pcc_cmd_checker.sv
// port assertions of the command and identity block
`timescale 1ns/100ps
`default_nettype none
module pcc_cmd_checker
	import pcc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire pcc_cfg_req_t cfg_req,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_rvalid,
	input wire logic io_hit,
	input wire logic mem_hit,
	input wire logic special_cycle,
	input wire logic io_claim,
	input wire logic mem_claim,
	input wire logic master_want,
	input wire logic master_req,
	input wire logic mwi_want,
	input wire logic use_write_invalidate,
	input wire logic b2b_other_ok,
	input wire logic addr_parity_err,
	input wire logic target_data_parity_err,
	input wire logic parity_error_oe_n,
	input wire logic system_error_oe_n,
	input wire logic detected_parity_flag,
	input wire pcc_cmd_t cmd_bits
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	io_gate_a: assert property (io_claim == (io_hit && !special_cycle && cmd_bits.io_space_allow))
		else $error("io claim wrong");
	mem_gate_a: assert property (mem_claim == (mem_hit && !special_cycle && cmd_bits.memory_space_allow))
		else $error("mem claim wrong");
	master_gate_a: assert property (master_req == (master_want && cmd_bits.bus_master_allow))
		else $error("bus request wrong");
	mwi_gate_a: assert property (use_write_invalidate == (mwi_want && cmd_bits.write_invalidate_allow))
		else $error("write invalidate wrong");
	b2b_off_a: assert property (!b2b_other_ok && !cmd_bits.fast_b2b)
		else $error("fast cycles allowed");
	serr_drive_a: assert property (!system_error_oe_n == $past(addr_parity_err && cmd_bits.system_error_report_en))
		else $error("system error drive wrong");
	perr_drive_a: assert property (!parity_error_oe_n == $past(target_data_parity_err && cmd_bits.parity_error_response))
		else $error("parity drive wrong");
	flag_set_a: assert property (addr_parity_err || target_data_parity_err |=> detected_parity_flag)
		else $error("parity flag not set");
	fixed_zero_a: assert property (cfg_rvalid && $past(cfg_req.dw) == 6'h01 |-> !(cfg_rdata & 32'h7FFFFEA8))
		else $error("fixed bits not zero");
endmodule
bind pcc_cmd_regs pcc_cmd_checker u_chk (.*);
`default_nettype wire

// ### verif/pcc_cmd_regs_tb_top.sv
// self-checking bench for the command and identity block
`timescale 1ns/100ps
`default_nettype none
`include "pcc_consts.svh"
module pcc_cmd_regs_tb_top
	import pcc_pkg::*;
;
	logic sys_clk = 1'h0, nrst = 1'h0, ep = 1'h0, el = 1'h0, ioh = 1'h0, memh = 1'h0, spc = 1'h0;
	logic mw = 1'h0, mwi = 1'h0, b2b = 1'h0, ape = 1'h0, tpe = 1'h0, ma = 1'h0, peer = 1'h0, line_n;
	logic rv, ioc, memc, mreq, uwi, b2ok, poe_n, soe_n, mdp, flag;
	logic [31:0] rdata;
	pcc_cfg_req_t req = '0;
	pcc_id_t eids = '0, ids;
	pcc_cmd_t cmdb;
	int n_errors = 0, cmp_count = 0, cyc = 0;
	always #10 sys_clk = ~sys_clk;
	pcc_cmd_regs DUT (.sys_clk(sys_clk), .nrst(nrst), .cfg_req(req), .cfg_rdata(rdata), .cfg_rvalid(rv),
		.eeprom_present(ep), .eeprom_load(el), .eeprom_ids(eids), .io_hit(ioh), .mem_hit(memh),
		.special_cycle(spc), .io_claim(ioc), .mem_claim(memc), .master_want(mw), .master_req(mreq),
		.mwi_want(mwi), .use_write_invalidate(uwi), .b2b_other_want(b2b), .b2b_other_ok(b2ok),
		.addr_parity_err(ape), .target_data_parity_err(tpe), .master_active(ma),
		.parity_error_line_n(line_n), .parity_error_out(), .parity_error_oe_n(poe_n),
		.system_error_out_n(), .system_error_oe_n(soe_n), .master_data_parity(mdp),
		.detected_parity_flag(flag), .cmd_bits(cmdb), .ids(ids));
	pcc_bus_peer u_peer (.peer_err(peer), .dev_oe_n(poe_n), .line_n(line_n));
	task automatic close_out;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic step;
		@(posedge sys_clk) #2;
	endtask
	task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d);
		req = '{rd: 1'h0, wr: 1'h1, dw: dw, be: be, wdata: d};
		step();
		req = '0;
		step();
	endtask
	task automatic rd(input logic [5:0] dw, input logic [31:0] exp);
		req = '{rd: 1'h1, wr: 1'h0, dw: dw, be: 4'hF, wdata: 32'h0};
		step();
		req = '0;
		chk({31'h0, rv}, 32'h1);
		chk(rdata, exp);
		step();
	endtask
	task automatic gates(input logic [15:0] c);
		#1 chk({ioc, memc, mreq, uwi, b2ok}, {c[0] & ~spc, c[1] & ~spc, c[2], c[4], 1'h0});
	endtask
	task automatic load(input logic p);
		ep = p;
		el = 1'h1;
		step();
		el = 1'h0;
		step();
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			close_out();
		end
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		#2 nrst = 1'h1;
		repeat (3) step();
		rd(6'h00, {`PCC_DEVICE_DEF, `PCC_VENDOR_DEF});
		rd(6'h01, 32'h0);
		eids = '{vendor: 16'h5A5A, device: 16'hC3C3};
		load(1'h1);
		rd(6'h00, 32'hC3C35A5A);
		chk(ids, 32'h5A5AC3C3);
		load(1'h0);
		rd(6'h00, {`PCC_DEVICE_DEF, `PCC_VENDOR_DEF});
		rd(6'h05, 32'h0);
		wr(6'h01, 4'hF, 32'hFFFFFFFF);
		rd(6'h01, 32'h157);
		wr(6'h01, 4'h1, 32'h0);
		rd(6'h01, 32'h100);
		{ioh, memh, mw, mwi, b2b} = 5'h1F;
		gates(16'h0100);
		wr(6'h01, 4'h3, 32'h157);
		gates(16'h0157);
		spc = 1'h1;
		gates(16'h0157);
		ape = 1'h1;
		step();
		ape = 1'h0;
		chk({soe_n, flag}, 32'h1);
		wr(6'h01, 4'h8, 32'h80000000);
		rd(6'h01, 32'h157);
		tpe = 1'h1;
		step();
		tpe = 1'h0;
		chk({poe_n, line_n}, 32'h0);
		{ma, peer} = 2'h3;
		step();
		{ma, peer} = 2'h0;
		chk(mdp, 32'h1);
		wr(6'h01, 4'hF, 32'h80000000);
		{ape, tpe, ma, peer} = 4'hF;
		step();
		{ape, tpe, ma, peer} = 4'h0;
		chk({poe_n, soe_n, mdp, flag}, 32'hD);
		wr(6'h01, 4'hF, 32'h157);
		nrst = 1'h0;
		step();
		nrst = 1'h1;
		repeat (3) step();
		rd(6'h01, 32'h0);
		close_out();
	end
endmodule
`default_nettype wire
